// ### rtl/flash_host_pkg.sv
// constants shared by the parallel flash command host
`default_nettype none
package flash_host_pkg;
	// clock and pin timing, figures in ns as printed, erase time in s
	localparam int CLK_PERIOD_NS = 20;
	localparam int WRITE_LOW_NS = 50;
	localparam int WRITE_HIGH_NS = 40;
	localparam int READ_ACCESS_NS = 70;
	localparam int TOGGLE_HIGH_PULSE_MIN_NS = 150;
	localparam int ERASE_CYCLE_MAX_S = 5;
	localparam int SYNC_STAGES = 2;
	// least times round up to whole clock cycles
	localparam int WRITE_LOW_CYC = (WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
		+ SYNC_STAGES + 1;
	localparam int TOGGLE_HIGH_CYC = (TOGGLE_HIGH_PULSE_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ERASE_TIMEOUT_CYC = ERASE_CYCLE_MAX_S * (1000000000 / CLK_PERIOD_NS);
	// widths
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	localparam int CNT_W = 4;
	localparam int STEP_W = 3;
	localparam int TMO_W = 28;
	localparam int TOGGLE_STATUS_BIT = 6;
	// command codes on the low data byte
	localparam logic [7:0] CODE_UNLOCK_1 = 8'hAA;
	localparam logic [7:0] CODE_UNLOCK_2 = 8'h55;
	localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
	localparam logic [7:0] CODE_ID_EXIT = 8'hF0;
	localparam logic [7:0] CODE_LOCKOUT = 8'h40;
	// command addresses on the low sixteen address bits
	localparam logic [15:0] ADDR_CMD_1 = 16'h5555;
	localparam logic [15:0] ADDR_CMD_2 = 16'h2AAA;
	localparam logic [15:0] ADDR_ZERO = 16'h0000;
	// sequence lengths
	localparam logic [STEP_W-1:0] LEN_NONE = 3'h0;
	localparam logic [STEP_W-1:0] LEN_SHORT = 3'h1;
	localparam logic [STEP_W-1:0] LEN_ENTRY = 3'h3;
	localparam logic [STEP_W-1:0] LEN_LONG = 3'h6;
	// user operations
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_CHIP_ERASE = 3'h1,
		OP_SECTOR_ERASE = 3'h2,
		OP_ID_ENTRY = 3'h3,
		OP_ID_READ = 3'h4,
		OP_ID_EXIT_LONG = 3'h5,
		OP_ID_EXIT_SHORT = 3'h6,
		OP_LOCKOUT = 3'h7
	} flash_op_t;
	// controller states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_WR_LO = 6'b00_0010,
		ST_WR_HI = 6'b00_0100,
		ST_RD_LO = 6'b00_1000,
		ST_RD_HI = 6'b01_0000,
		ST_DONE = 6'b10_0000
	} host_state_t;
endpackage : flash_host_pkg
`default_nettype wire

// ### rtl/flash_cmd_host.sv
// host that drives erase, identification, lockout and toggle polling on a parallel flash
`default_nettype none
module flash_cmd_host #(
	parameter int unsigned TIMEOUT_CYC = flash_host_pkg::ERASE_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// user command port
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire flash_host_pkg::flash_op_t cmd_op_i,
	input wire logic [flash_host_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic id_select_address_bit_i,
	// user result port
	output logic done_o,
	output logic timeout_o,
	output logic [flash_host_pkg::DATA_W-1:0] rd_data_o,
	// flash pins
	output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o,
	output logic chip_sel_n_o,
	output logic out_en_n_o,
	output logic write_n_o,
	output logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i
);
	import flash_host_pkg::*;

	localparam logic [CNT_W-1:0] WR_LO_LOAD = CNT_W'(WRITE_LOW_CYC - 1);
	localparam logic [CNT_W-1:0] WR_HI_LOAD = CNT_W'(WRITE_HIGH_CYC - 1);
	localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(READ_CYC - 1);
	localparam logic [CNT_W-1:0] TGL_HI_LOAD = CNT_W'(TOGGLE_HIGH_CYC - 1);
	localparam logic [TMO_W-1:0] TMO_LIMIT = TMO_W'(TIMEOUT_CYC);

	// reset release synchroniser, assert async, release on clock
	logic rst_meta_ff;
	logic rst_n_ff;
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// data pins come from an unclocked part, two flops before use
	logic [DATA_W-1:0] dq_meta_ff;
	logic [DATA_W-1:0] dq_sync_ff;
	always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			dq_meta_ff <= '0;
			dq_sync_ff <= '0;
		end else begin
			dq_meta_ff <= flash_dq_i;
			dq_sync_ff <= dq_meta_ff;
		end
	end

	// sequence table: {address, data} of write number step
	function automatic logic [23:0] seq_word(input flash_op_t op, input logic [STEP_W-1:0] step,
			input logic [15:0] fin_addr);
		logic [15:0] a;
		logic [7:0] d;
		a = ADDR_CMD_1;
		d = CODE_UNLOCK_1;
		unique case (step)
			3'h0: begin
				// short exit is a lone exit code
				if (op == OP_ID_EXIT_SHORT) begin
					a = ADDR_ZERO;
					d = CODE_ID_EXIT;
				end
			end
			3'h1: begin
				a = ADDR_CMD_2;
				d = CODE_UNLOCK_2;
			end
			3'h2: begin
				if (op == OP_ID_ENTRY) begin
					d = CODE_ID_ENTRY;
				end else if (op == OP_ID_EXIT_LONG) begin
					d = CODE_ID_EXIT;
				end else begin
					d = CODE_ERASE_SETUP;
				end
			end
			3'h3: begin
				d = CODE_UNLOCK_1;
			end
			3'h4: begin
				a = ADDR_CMD_2;
				d = CODE_UNLOCK_2;
			end
			default: begin
				if (op == OP_SECTOR_ERASE) begin
					a = fin_addr;
					d = CODE_SECTOR_ERASE;
				end else if (op == OP_LOCKOUT) begin
					d = CODE_LOCKOUT;
				end else begin
					d = CODE_CHIP_ERASE;
				end
			end
		endcase
		return {a, d};
	endfunction : seq_word

	// number of command writes per operation
	function automatic logic [STEP_W-1:0] seq_len(input flash_op_t op);
		unique case (op)
			OP_READ, OP_ID_READ: return LEN_NONE;
			OP_ID_ENTRY, OP_ID_EXIT_LONG: return LEN_ENTRY;
			OP_ID_EXIT_SHORT: return LEN_SHORT;
			default: return LEN_LONG;
		endcase
	endfunction : seq_len

	// controller state
	host_state_t state_ff, nxt_state;
	flash_op_t op_ff, nxt_op;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [STEP_W-1:0] step_ff, nxt_step;
	logic [15:0] fin_addr_ff, nxt_fin_addr;
	logic first_ff, nxt_first;             // first poll read has no reference yet
	logic tgl_prev_ff, nxt_tgl_prev;       // toggle bit of the previous poll read
	logic [TMO_W-1:0] tmo_ff, nxt_tmo;     // cycles spent polling
	logic timeout_ff, nxt_timeout;
	logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
	// pin registers
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic ce_n_ff, nxt_ce_n;
	logic oe_n_ff, nxt_oe_n;
	logic we_n_ff, nxt_we_n;
	logic [DATA_W-1:0] dq_out_ff, nxt_dq_out;
	logic dq_oe_ff, nxt_dq_oe;
	logic [23:0] word;                     // table entry of the next write
	logic polls;                           // operation ends with toggle polling
	logic tgl_now;

	// next-state logic for the whole sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_cnt = cnt_ff;
		nxt_step = step_ff;
		nxt_fin_addr = fin_addr_ff;
		nxt_first = first_ff;
		nxt_tgl_prev = tgl_prev_ff;
		nxt_tmo = tmo_ff;
		nxt_timeout = timeout_ff;
		nxt_rd_data = rd_data_ff;
		nxt_addr = addr_ff;
		nxt_ce_n = ce_n_ff;
		nxt_oe_n = oe_n_ff;
		nxt_we_n = we_n_ff;
		nxt_dq_out = dq_out_ff;
		nxt_dq_oe = dq_oe_ff;
		polls = (op_ff == OP_CHIP_ERASE) || (op_ff == OP_SECTOR_ERASE) || (op_ff == OP_LOCKOUT);
		tgl_now = dq_sync_ff[TOGGLE_STATUS_BIT];
		word = seq_word(op_ff, nxt_step, fin_addr_ff);
		unique case (state_ff)
			ST_IDLE: begin
				if (cmd_valid_i) begin
					nxt_op = cmd_op_i;
					nxt_step = '0;
					nxt_fin_addr = cmd_addr_i[15:0];
					nxt_first = 1'b1;
					nxt_tmo = '0;
					nxt_timeout = 1'b0;
					if (seq_len(cmd_op_i) != LEN_NONE) begin
						// command address on low sixteen bits
						word = seq_word(cmd_op_i, '0, cmd_addr_i[15:0]);
						nxt_addr = {1'b0, word[23:8]};
						nxt_dq_out = {8'h00, word[7:0]};
						nxt_dq_oe = 1'b1;
						nxt_ce_n = 1'b0;
						nxt_we_n = 1'b0;
						nxt_cnt = WR_LO_LOAD;
						nxt_state = ST_WR_LO;
					end else begin
						nxt_addr = (cmd_op_i == OP_ID_READ) ?
							{{(ADDR_W-1){1'b0}}, id_select_address_bit_i} : cmd_addr_i;
						nxt_ce_n = 1'b0;
						nxt_oe_n = 1'b0;
						nxt_cnt = RD_LOAD;
						nxt_state = ST_RD_LO;
					end
				end
			end
			ST_WR_LO: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == '0) begin
					nxt_ce_n = 1'b1;
					nxt_we_n = 1'b1;
					nxt_cnt = WR_HI_LOAD;
					nxt_state = ST_WR_HI;
				end
			end
			ST_WR_HI: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == '0) begin
					nxt_step = step_ff + 1'b1;
					word = seq_word(op_ff, nxt_step, fin_addr_ff);
					if (nxt_step < seq_len(op_ff)) begin
						nxt_addr = {1'b0, word[23:8]};
						nxt_dq_out = {8'h00, word[7:0]};
						nxt_ce_n = 1'b0;
						nxt_we_n = 1'b0;
						nxt_cnt = WR_LO_LOAD;
						nxt_state = ST_WR_LO;
					end else if (polls) begin
						nxt_dq_oe = 1'b0;
						nxt_ce_n = 1'b0;
						nxt_oe_n = 1'b0;
						nxt_cnt = RD_LOAD;
						nxt_state = ST_RD_LO;
					end else begin
						nxt_dq_oe = 1'b0;
						nxt_state = ST_DONE;
					end
				end
			end
			ST_RD_LO: begin
				nxt_cnt = cnt_ff - 1'b1;
				nxt_tmo = tmo_ff + 1'b1;
				if (cnt_ff == '0) begin
					nxt_ce_n = 1'b1;
					nxt_oe_n = 1'b1;
					nxt_rd_data = dq_sync_ff;
					nxt_tgl_prev = tgl_now;
					nxt_first = 1'b0;
					if (!polls || (!first_ff && (tgl_now == tgl_prev_ff))) begin
						nxt_state = ST_DONE;
					end else begin
						nxt_cnt = TGL_HI_LOAD;
						nxt_state = ST_RD_HI;
					end
				end
			end
			ST_RD_HI: begin
				nxt_cnt = cnt_ff - 1'b1;
				nxt_tmo = tmo_ff + 1'b1;
				if (tmo_ff >= TMO_LIMIT) begin
					// a stuck part must not hang the host forever
					nxt_timeout = 1'b1;
					nxt_state = ST_DONE;
				end else if (cnt_ff == '0) begin
					nxt_ce_n = 1'b0;
					nxt_oe_n = 1'b0;
					nxt_cnt = RD_LOAD;
					nxt_state = ST_RD_LO;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// register stage for the sequencer and pins
	always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			state_ff <= ST_IDLE;
			op_ff <= OP_READ;
			cnt_ff <= '0;
			step_ff <= '0;
			fin_addr_ff <= '0;
			first_ff <= 1'b1;
			tgl_prev_ff <= 1'b0;
			tmo_ff <= '0;
			timeout_ff <= 1'b0;
			rd_data_ff <= '0;
			addr_ff <= '0;
			ce_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			dq_out_ff <= '0;
			dq_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			cnt_ff <= nxt_cnt;
			step_ff <= nxt_step;
			fin_addr_ff <= nxt_fin_addr;
			first_ff <= nxt_first;
			tgl_prev_ff <= nxt_tgl_prev;
			tmo_ff <= nxt_tmo;
			timeout_ff <= nxt_timeout;
			rd_data_ff <= nxt_rd_data;
			addr_ff <= nxt_addr;
			ce_n_ff <= nxt_ce_n;
			oe_n_ff <= nxt_oe_n;
			we_n_ff <= nxt_we_n;
			dq_out_ff <= nxt_dq_out;
			dq_oe_ff <= nxt_dq_oe;
		end
	end

	// handshakes combinational, data and pins from flops
	// no ready while the reset copy still holds the sequencer, or a request would be lost
	assign cmd_ready_o = (state_ff == ST_IDLE) && rst_n_ff;
	assign done_o = (state_ff == ST_DONE);
	assign timeout_o = timeout_ff;
	assign rd_data_o = rd_data_ff;
	assign flash_addr_o = addr_ff;
	assign chip_sel_n_o = ce_n_ff;
	assign out_en_n_o = oe_n_ff;
	assign write_n_o = we_n_ff;
	assign flash_dq_o = dq_out_ff;
	assign flash_dq_oe_o = dq_oe_ff;
endmodule : flash_cmd_host
`default_nettype wire

// ### verification/flash_cmd_host_assertions.sv
// assertion checker bound to the flash command host
`default_nettype none
module flash_cmd_host_assertions (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// user port
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire flash_host_pkg::flash_op_t cmd_op_i,
	input wire logic [16:0] cmd_addr_i,
	input wire logic done_o,
	// flash pins
	input wire logic [16:0] flash_addr_o,
	input wire logic out_en_n_o,
	input wire logic write_n_o,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import flash_host_pkg::*;
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// last op taken, its sector and the last command word
	flash_op_t op_ff;
	logic [15:0] sec_ff, wa_ff;
	logic [7:0] wd_ff;
	// polling ops read status at the last write address
	wire logic poll = op_ff inside {OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_LOCKOUT};
	// no reset needed: an unknown op only leaves the checks vacuous
	always_ff @(posedge ref_clk_i) begin
		if (cmd_valid_i && cmd_ready_o) begin
			op_ff <= cmd_op_i;
			sec_ff <= cmd_addr_i[15:0];
		end
		if (!write_n_o) begin
			wd_ff <= flash_dq_o[7:0];
			wa_ff <= flash_addr_o[15:0];
		end
	end
	chk_oe_write: assert property (
		!write_n_o |-> out_en_n_o && flash_dq_oe_o) else $error("oe low in write");
	chk_cmd_fields: assert property (
		!write_n_o |-> !flash_dq_o[15:8] && !flash_addr_o[16]) else $error("upper bits set");
	chk_chip_final: assert property (
		$fell(out_en_n_o) && op_ff == OP_CHIP_ERASE |-> wd_ff == 8'h10 && wa_ff == 16'h5555)
		else $error("bad chip erase word");
	chk_sec_final: assert property (
		$fell(out_en_n_o) && op_ff == OP_SECTOR_ERASE |-> wd_ff == 8'h30 && wa_ff == sec_ff)
		else $error("bad sector erase word");
	chk_tog_high: assert property (
		$rose(out_en_n_o) && poll && !done_o |-> out_en_n_o[*8]) else $error("short oe high");
	chk_poll_addr: assert property (
		!out_en_n_o && poll |-> flash_addr_o[15:0] == wa_ff) else $error("poll address moved");
	// done is one cycle and frees the port
	chk_done_pulse: assert property (
		done_o |=> !done_o && cmd_ready_o) else $error("done not a pulse");
	// every read holds oe low for seven cycles: the access time rounded up, two sync stages and one more
	chk_read_len: assert property (
		$fell(out_en_n_o) |-> !out_en_n_o[*7] ##1 out_en_n_o) else $error("read length");
endmodule : flash_cmd_host_assertions
bind flash_cmd_host flash_cmd_host_assertions flash_cmd_host_assertions_i (.ref_clk_i,
	.reset_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_addr_i, .done_o, .flash_addr_o,
	.out_en_n_o, .write_n_o, .flash_dq_o, .flash_dq_oe_o);
`default_nettype wire

// ### verification/flash_model.sv
// behavioural flash answering erase, id, lockout and toggle polling
`default_nettype none
module flash_model #(
	parameter int BUSY_READS = 3,
	// arbitrary identity values
	parameter logic [15:0] MAKER_CODE = 16'h0A5C,
	parameter logic [15:0] DEVICE_CODE = 16'h0C3E
) (
	// host pins
	input wire logic [16:0] addr_i,
	input wire logic chip_sel_n_i,
	input wire logic out_en_n_i,
	input wire logic write_n_i,
	input wire logic [15:0] dq_i,
	// read data
	output logic [15:0] dq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic id_mode = 1'b0;
	logic tog = 1'b1;
	logic lock = 1'b0;
	logic stat = 1'b0;
	int step = 0;
	int busy = 0;
	logic [7:0] last_code = 8'h00;
	logic [15:0] last_addr = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] q, ea;
	logic [7:0] ed;
	// expected unlock word for the current step
	assign ea = step % 3 == 1 ? 16'h2AAA : 16'h5555;
	assign ed = step % 3 == 1 ? 8'h55 : (step == 2 ? 8'h80 : 8'hAA);
	always @(posedge write_n_i) begin
		stat = 1'b0;
		if (id_mode && dq_i[7:0] == 8'hF0) begin
			id_mode = 1'b0;
			step = 0;
		end else if (step == 2 && addr_i[15:0] == 16'h5555 && dq_i[7:0] != 8'h80) begin
			id_mode = dq_i[7:0] == 8'h90;
			step = 0;
		end else if (step == 5) begin
			if (dq_i[7:0] inside {8'h10, 8'h30, 8'h40}) begin
				last_code = dq_i[7:0];
				last_addr = addr_i[15:0];
				lock = lock | (dq_i[7:0] == 8'h40);
				busy = BUSY_READS;
				stat = 1'b1;
			end
			step = 0;
		end else begin
			step = (addr_i[15:0] == ea && dq_i[7:0] == ed) ? step + 1 : 0;
		end
	end
	// toggle flips per read until the work ends
	always @(negedge out_en_n_i) begin
		if (busy > 0) begin
			tog = ~tog;
			busy = busy - 1;
		end
	end
	// id codes only with A16..A1 low
	assign q = stat ? {9'h000, tog, 6'h00} : (id_mode && !addr_i[16:1]) ?
		(addr_i[0] ? DEVICE_CODE : MAKER_CODE) : ~addr_i[15:0];
	// a released bus shows the inverse of the last word, never a held value
	always @(posedge out_en_n_i) last_q = q;
	assign dq_o = (!chip_sel_n_i && !out_en_n_i) ? q : ~last_q;
endmodule : flash_model
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench: command host against a behavioural flash
`default_nettype none
`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
	$display("[ERR] %s expected %h seen %h", what, exp, got); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_host_pkg::*;
	// arbitrary identity values for the model
	localparam logic [15:0] MAKER = 16'h0A5C;
	localparam logic [15:0] DEVICE = 16'h0C3E;
	int err_count = 0;
	int n_compared = 0;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	flash_op_t cmd_op_i = OP_READ;
	logic [16:0] cmd_addr_i = 17'h0_0000;
	logic id_select_address_bit_i = 1'b0;
	logic cmd_ready_o, done_o, timeout_o, chip_sel_n_o, out_en_n_o, write_n_o, flash_dq_oe_o;
	logic [15:0] rd_data_o, flash_dq_o, flash_dq_i, model_dq;
	logic [16:0] flash_addr_o;
	// bus level: host while its enable is high, the model otherwise
	assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : model_dq;
	// short poll limit so a stuck erase cannot stall the run
	flash_cmd_host #(.TIMEOUT_CYC(400)) flash_cmd_host_i (.ref_clk_i, .reset_n_i, .cmd_valid_i,
		.cmd_ready_o, .cmd_op_i, .cmd_addr_i, .id_select_address_bit_i, .done_o, .timeout_o,
		.rd_data_o, .flash_addr_o, .chip_sel_n_o, .out_en_n_o, .write_n_o, .flash_dq_o,
		.flash_dq_oe_o, .flash_dq_i);
	flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) flash_model_i (
		.addr_i(flash_addr_o), .chip_sel_n_i(chip_sel_n_o), .out_en_n_i(out_en_n_o),
		.write_n_i(write_n_o), .dq_i(flash_dq_i), .dq_o(model_dq));
	initial forever #10 ref_clk_i = ~ref_clk_i;
	// verdict and end of run
	task automatic conclude();
		if (err_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// one command, held until taken, then a bounded wait for done
	task automatic run_op(input flash_op_t op, input logic [16:0] a, input logic sel);
		int n = 0;
		@(posedge ref_clk_i);
		#1;
		cmd_op_i = op;
		cmd_addr_i = a;
		id_select_address_bit_i = sel;
		cmd_valid_i = 1'b1;
		while (cmd_ready_o !== 1'b1 && n < 1000) begin
			@(negedge ref_clk_i);
			n++;
		end
		@(posedge ref_clk_i);
		#1;
		cmd_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 1000) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n >= 1000) begin
			err_count++;
			conclude();
		end
	endtask : run_op
	// id entry, both codes with stray upper address, then exit to array reads
	task automatic t_ident(input flash_op_t ex);
		run_op(OP_ID_ENTRY, 17'h0_0000, 1'b0);
		run_op(OP_ID_READ, 17'h1_FFFE, 1'b0);
		`CHECK("maker code", MAKER, rd_data_o)
		run_op(OP_ID_READ, 17'h1_FFFE, 1'b1);
		`CHECK("device code", DEVICE, rd_data_o)
		run_op(ex, 17'h0_0000, 1'b0);
		run_op(OP_READ, 17'h0_0001, 1'b0);
		`CHECK("array word", 16'hFFFE, rd_data_o)
	endtask : t_ident
	// final word, end of polling and lock state after erase or lockout
	task automatic t_erase(input flash_op_t op, input logic [7:0] code,
		input logic [15:0] fa, input logic lk);
		run_op(op, 17'h1_3000, 1'b0);
		`CHECK("final code", code, flash_model_i.last_code)
		`CHECK("final address", fa, flash_model_i.last_addr)
		`CHECK("poll end", 0, flash_model_i.busy)
		`CHECK("timeout", 1'b0, timeout_o)
		`CHECK("lock", lk, flash_model_i.lock)
	endtask : t_erase
	// reset, then the scenarios back to back
	initial begin
		repeat (2) @(posedge ref_clk_i);
		#1 reset_n_i = 1'b1;
		// the host releases its own reset copy two edges later
		repeat (2) @(posedge ref_clk_i);
		t_ident(OP_ID_EXIT_LONG);
		t_ident(OP_ID_EXIT_SHORT);
		t_erase(OP_CHIP_ERASE, 8'h10, 16'h5555, 1'b0);
		t_erase(OP_SECTOR_ERASE, 8'h30, 16'h3000, 1'b0);
		t_erase(OP_LOCKOUT, 8'h40, 16'h5555, 1'b1);
		conclude();
	end
endmodule : testbench
`default_nettype wire
